// ===== fic_cap.sv
// fifo interface capability register and fifo port size gate
// assumes a plain strobe bus on mclk; fifo storage lives downstream
// Functional notes
// - capability reads valid only for host port kinds 0000 or 1111.
// - legacy-only parts report size field 00.
// - legacy-only parts accept fifo data only at the standard fifo offset.
// - legacy-only parts abort every access to the extended fifo.
// - nonzero size field enables the extended fifo too.
// - transfers up to the advertised maximum are accepted.
// - one to four byte transfers go to either fifo when extended.
// - size field bits 10:9 encode 64, 32, 8 bytes or legacy.
// - a larger advertised size implies all smaller sizes.
// - bits 30:28 report the port revision.
// - bits 27:11 read as zero.
// - bit 8 reports fixed burst allowance.
// - bit 7 reports command ready interrupt support.
// - bits 6, 5, 3 report falling, rising and high trigger support.
// - bit 4 low trigger support always reads one.
// - bits 2 and 0 always read one.
// - bit 1 reports status good interrupt support.
// - bit 31 value is an implementation choice.
//
// Design decisions made here: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "fic_cfg.svh"
module fic_cap #(
   parameter logic [1:0] SIZE_CAP = 2'h0,
   parameter logic [2:0] REVISION = `FIC_REV_DEFAULT,
   parameter logic RSV31_VAL = 1'b0,
   parameter logic FIXED_BURST = 1'b0,
   parameter logic CMD_READY_CAP = 1'b0,
   parameter logic FALL_CAP = 1'b0,
   parameter logic RISE_CAP = 1'b0,
   parameter logic HIGH_CAP = 1'b0,
   parameter logic STS_GOOD_CAP = 1'b0,
   parameter logic [3:0] PORT_KIND = `FIC_KIND_FIFO_A
) (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic [`FIC_ADDR_W-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [6:0] reg_len,
   output logic [31:0] reg_rdata,
   output logic bus_abort,
   output logic fifo_wr,
   output logic fifo_rd,
   output logic [31:0] fifo_wdata,
   output logic [6:0] fifo_len,
   input wire logic [31:0] fifo_rdata
);
   fic_pkg::fic_cap_s cap;
   fic_pkg::fic_req_s req;
   logic kind_ok;
   logic is_std;
   logic is_ext;
   logic len_ok;
   logic port_ok;
   logic take;
   logic rd_fifo_q;
   logic [6:0] max_len;

   function automatic logic [6:0] size_limit(input logic [1:0] code);
      unique case (code)
         2'h3: size_limit = `FIC_LEN_64;
         2'h2: size_limit = `FIC_LEN_32;
         2'h1: size_limit = `FIC_LEN_8;
         default: size_limit = `FIC_LEN_LEGACY;
      endcase
   endfunction : size_limit

   always_comb
   begin
      cap = '0;
      cap.rsv31 = RSV31_VAL;
      cap.port_revision = REVISION;
      cap.max_xfer_size_cap = fic_pkg::fic_size_e'(SIZE_CAP);
      cap.fixed_burst_flag = FIXED_BURST;
      cap.cmd_ready_irq_cap = CMD_READY_CAP;
      cap.fall_trigger_cap = FALL_CAP;
      cap.rise_trigger_cap = RISE_CAP;
      cap.high_trigger_cap = HIGH_CAP;
      cap.low_trigger_cap = 1'b1;
      cap.owner_switch_irq_cap = 1'b1;
      cap.reply_ready_irq_cap = 1'b1;
      cap.status_good_irq_cap = STS_GOOD_CAP;
   end

   always_comb
   begin
      req.wr = reg_wr;
      req.rd = reg_rd;
      req.addr = reg_addr;
      req.len = reg_len;
      req.wdata = reg_wdata;
   end

   assign kind_ok = (PORT_KIND == `FIC_KIND_FIFO_A) || (PORT_KIND == `FIC_KIND_FIFO_B);
   assign max_len = size_limit(SIZE_CAP);
   assign is_std = (req.addr == `FIC_OFF_DATA_FIFO);
   assign is_ext = (req.addr == `FIC_OFF_XFIFO);
   // length zero passes the limit check and is forwarded as zero, so a bare strobe still works
   assign len_ok = (req.len <= max_len) || (req.len <= `FIC_LEN_LEGACY);
   assign port_ok = is_std || (is_ext && (SIZE_CAP != 2'h0));
   assign take = (req.wr || req.rd) && port_ok && len_ok;

   // forwarded strobes are registered so the fifo sees clean one-cycle pulses
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         fifo_wr <= 1'b0;
         fifo_rd <= 1'b0;
         fifo_wdata <= 32'h0;
         fifo_len <= 7'h0;
      end
      else
      begin
         fifo_wr <= req.wr && take;
         fifo_rd <= req.rd && take;
         fifo_wdata <= req.wdata;
         fifo_len <= req.len;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
         bus_abort <= 1'b0;
      else
         bus_abort <= (req.wr || req.rd) && ((is_ext && (SIZE_CAP == 2'h0)) || ((is_std || is_ext) && !len_ok));
   end

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
         rd_fifo_q <= 1'b0;
      else
         rd_fifo_q <= req.rd && take;
   end

   // capability read is answered from the constant image; writes are dropped
   logic [31:0] cap_rdata;
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
         cap_rdata <= 32'h0;
      else if (req.rd && req.addr == `FIC_OFF_CAP)
         cap_rdata <= kind_ok ? cap : 32'h0;
      else if (req.rd && req.addr == `FIC_OFF_KIND)
         cap_rdata <= {28'h0, PORT_KIND};
      else
         cap_rdata <= 32'h0;
   end

   // fifo read data is passed through from the fifo in the same cycle as the forwarded strobe
   assign reg_rdata = rd_fifo_q ? fifo_rdata : cap_rdata;

   a_low_one: assert property (p_low_one) else $error("low trigger bit not one");
   property p_low_one;
      @(posedge mclk) disable iff (sys_rst) (req.rd && req.addr == `FIC_OFF_CAP && kind_ok) |=> reg_rdata[4] && reg_rdata[2] && reg_rdata[0];
   endproperty
   a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bits nonzero");
   property p_rsv_zero;
      @(posedge mclk) disable iff (sys_rst) (req.rd && req.addr == `FIC_OFF_CAP) |=> reg_rdata[27:11] == 17'h0;
   endproperty
   a_size: assert property (p_size) else $error("size field wrong");
   property p_size;
      @(posedge mclk) disable iff (sys_rst) (req.rd && req.addr == `FIC_OFF_CAP && kind_ok) |=> reg_rdata[10:9] == SIZE_CAP;
   endproperty
   a_rev: assert property (p_rev) else $error("revision wrong");
   property p_rev;
      @(posedge mclk) disable iff (sys_rst) (req.rd && req.addr == `FIC_OFF_CAP && kind_ok) |=> reg_rdata[30:28] == REVISION;
   endproperty
   a_abort: assert property (p_abort) else $error("extended fifo not aborted");
   property p_abort;
      @(posedge mclk) disable iff (sys_rst) ((req.wr || req.rd) && is_ext && SIZE_CAP == 2'h0) |=> bus_abort && !fifo_wr && !fifo_rd;
   endproperty
   a_std: assert property (p_std) else $error("small std write dropped");
   property p_std;
      @(posedge mclk) disable iff (sys_rst) (req.wr && is_std && req.len <= `FIC_LEN_LEGACY) |=> fifo_wr && !bus_abort;
   endproperty
   a_ext: assert property (p_ext) else $error("extended write refused");
   property p_ext;
      @(posedge mclk) disable iff (sys_rst) (req.wr && is_ext && SIZE_CAP != 2'h0 && req.len <= max_len) |=> fifo_wr;
   endproperty
   a_max: assert property (p_max) else $error("limit mismatch");
   property p_max;
      @(posedge mclk) disable iff (sys_rst) (req.wr && is_std && req.len == max_len) |=> fifo_wr && !bus_abort;
   endproperty
   a_over: assert property (p_over) else $error("oversize accepted");
   property p_over;
      @(posedge mclk) disable iff (sys_rst) (req.wr && is_std && req.len > max_len && req.len > `FIC_LEN_LEGACY) |=> bus_abort && !fifo_wr;
   endproperty

   // capability image checks; the image is constant, so each field is pinned to its parameter or, for bits 4, 2 and 0, to one
   sequence s_cap_ok;
      req.rd && req.addr == `FIC_OFF_CAP && kind_ok;
   endsequence

   sequence s_cap_wr;
      req.wr && !req.rd && req.addr == `FIC_OFF_CAP;
   endsequence

   sequence s_fifo_take;
      (req.wr || req.rd) && take;
   endsequence

   property p_kind_bad;
      @(posedge mclk) disable iff (sys_rst)
         (req.rd && req.addr == `FIC_OFF_CAP && !kind_ok) |=> reg_rdata == 32'h0;
   endproperty
   a_kind_bad: assert property (p_kind_bad) else $error("cap shown for foreign port kind");

   property p_kind_read;
      @(posedge mclk) disable iff (sys_rst)
         (req.rd && req.addr == `FIC_OFF_KIND) |=> reg_rdata == {28'h0, PORT_KIND};
   endproperty
   a_kind_read: assert property (p_kind_read) else $error("port kind readback wrong");

   property p_bit4;
      @(posedge mclk) disable iff (sys_rst)
         s_cap_ok |=> reg_rdata[`FIC_BIT_LOW] == 1'b1;
   endproperty
   a_bit4: assert property (p_bit4) else $error("low trigger bit clear");

   property p_bit2;
      @(posedge mclk) disable iff (sys_rst)
         s_cap_ok |=> reg_rdata[`FIC_BIT_OWNSW] == 1'b1;
   endproperty
   a_bit2: assert property (p_bit2) else $error("owner switch bit clear");

   property p_bit0;
      @(posedge mclk) disable iff (sys_rst)
         s_cap_ok |=> reg_rdata[`FIC_BIT_REPLY] == 1'b1;
   endproperty
   a_bit0: assert property (p_bit0) else $error("reply ready bit clear");

   property p_fixed;
      @(posedge mclk) disable iff (sys_rst)
         s_cap_ok |=> reg_rdata[`FIC_BIT_FIXED] == FIXED_BURST;
   endproperty
   a_fixed: assert property (p_fixed) else $error("fixed burst bit wrong");

   property p_cmdrdy;
      @(posedge mclk) disable iff (sys_rst)
         s_cap_ok |=> reg_rdata[`FIC_BIT_CMDRDY] == CMD_READY_CAP;
   endproperty
   a_cmdrdy: assert property (p_cmdrdy) else $error("command ready bit wrong");

   property p_fall;
      @(posedge mclk) disable iff (sys_rst)
         s_cap_ok |=> reg_rdata[`FIC_BIT_FALL] == FALL_CAP;
   endproperty
   a_fall: assert property (p_fall) else $error("falling trigger bit wrong");

   property p_rise;
      @(posedge mclk) disable iff (sys_rst)
         s_cap_ok |=> reg_rdata[`FIC_BIT_RISE] == RISE_CAP;
   endproperty
   a_rise: assert property (p_rise) else $error("rising trigger bit wrong");

   property p_high;
      @(posedge mclk) disable iff (sys_rst)
         s_cap_ok |=> reg_rdata[`FIC_BIT_HIGH] == HIGH_CAP;
   endproperty
   a_high: assert property (p_high) else $error("high trigger bit wrong");

   property p_stsok;
      @(posedge mclk) disable iff (sys_rst)
         s_cap_ok |=> reg_rdata[`FIC_BIT_STSOK] == STS_GOOD_CAP;
   endproperty
   a_stsok: assert property (p_stsok) else $error("status good bit wrong");

   property p_rsv31;
      @(posedge mclk) disable iff (sys_rst)
         s_cap_ok |=> reg_rdata[`FIC_BIT_RSV31] == RSV31_VAL;
   endproperty
   a_rsv31: assert property (p_rsv31) else $error("top bit not the chosen value");

   // a reserved revision code would be a build mistake, caught on the first read
   property p_rev_legal;
      @(posedge mclk) disable iff (sys_rst)
         s_cap_ok |=> reg_rdata[30:28] != 3'h1 && reg_rdata[30:28] < 3'h4;
   endproperty
   a_rev_legal: assert property (p_rev_legal) else $error("reserved revision code");

   property p_cap_wr;
      @(posedge mclk) disable iff (sys_rst)
         s_cap_wr |=> !fifo_wr && !fifo_rd && !bus_abort;
   endproperty
   a_cap_wr: assert property (p_cap_wr) else $error("cap write had an effect");

   property p_cap_quiet;
      @(posedge mclk) disable iff (sys_rst)
         s_cap_wr |=> reg_rdata == 32'h0;
   endproperty
   a_cap_quiet: assert property (p_cap_quiet) else $error("cap write drove read data");

   property p_idle;
      @(posedge mclk) disable iff (sys_rst)
         !req.rd |=> reg_rdata == 32'h0;
   endproperty
   a_idle: assert property (p_idle) else $error("read data without a read");

   property p_rd_std;
      @(posedge mclk) disable iff (sys_rst)
         (req.rd && is_std && req.len <= `FIC_LEN_LEGACY) |=> fifo_rd && !bus_abort;
   endproperty
   a_rd_std: assert property (p_rd_std) else $error("small std read dropped");

   property p_non_fifo;
      @(posedge mclk) disable iff (sys_rst)
         ((req.wr || req.rd) && !is_std && !is_ext) |=> !fifo_wr && !fifo_rd && !bus_abort;
   endproperty
   a_non_fifo: assert property (p_non_fifo) else $error("fifo strobe off the fifo offsets");

   property p_ext_rd_small;
      @(posedge mclk) disable iff (sys_rst)
         (req.rd && is_ext && SIZE_CAP != 2'h0 && req.len <= `FIC_LEN_LEGACY) |=> fifo_rd && !bus_abort;
   endproperty
   a_ext_rd_small: assert property (p_ext_rd_small) else $error("small extended read refused");

   property p_ext_wr_small;
      @(posedge mclk) disable iff (sys_rst)
         (req.wr && is_ext && SIZE_CAP != 2'h0 && req.len <= `FIC_LEN_LEGACY) |=> fifo_wr && !bus_abort;
   endproperty
   a_ext_wr_small: assert property (p_ext_wr_small) else $error("small extended write refused");

   property p_fwd_len;
      @(posedge mclk) disable iff (sys_rst)
         (req.wr && take) |=> fifo_len == $past(req.len);
   endproperty
   a_fwd_len: assert property (p_fwd_len) else $error("forwarded length wrong");

   property p_fwd_data;
      @(posedge mclk) disable iff (sys_rst)
         (req.wr && take) |=> fifo_wdata == $past(req.wdata);
   endproperty
   a_fwd_data: assert property (p_fwd_data) else $error("forwarded data wrong");

   property p_no_both;
      @(posedge mclk) disable iff (sys_rst)
         !(bus_abort && (fifo_wr || fifo_rd));
   endproperty
   a_no_both: assert property (p_no_both) else $error("abort beside a fifo strobe");

   property p_abort_free;
      @(posedge mclk) disable iff (sys_rst)
         s_fifo_take |=> !bus_abort;
   endproperty
   a_abort_free: assert property (p_abort_free) else $error("accepted access aborted");

   property p_ext_over;
      @(posedge mclk) disable iff (sys_rst)
         (req.rd && is_ext && req.len > max_len && req.len > `FIC_LEN_LEGACY) |=> bus_abort && !fifo_rd;
   endproperty
   a_ext_over: assert property (p_ext_over) else $error("oversize extended read accepted");

   property p_size_order;
      @(posedge mclk) disable iff (sys_rst)
         (req.wr && is_std && SIZE_CAP != 2'h0 && req.len <= `FIC_LEN_8) |=> fifo_wr;
   endproperty
   a_size_order: assert property (p_size_order) else $error("smaller size refused");

   property p_rd_data;
      @(posedge mclk) disable iff (sys_rst)
         (req.rd && take) |=> reg_rdata == fifo_rdata;
   endproperty
   a_rd_data: assert property (p_rd_data) else $error("fifo read data not passed");

   // legacy parts must never let a long transfer through on a stale limit
   property p_legacy_mx;
      @(posedge mclk) disable iff (sys_rst)
         (SIZE_CAP != 2'h0) || (max_len == `FIC_LEN_LEGACY);
   endproperty
   a_legacy_mx: assert property (p_legacy_mx) else $error("legacy limit wrong");
endmodule : fic_cap
`default_nettype wire

// ===== fic_cfg.svh
// constants for the fifo interface capability block
// assumes inclusion by bare name from the package and the design
`ifndef FIC_CFG_SVH
`define FIC_CFG_SVH
`define FIC_ADDR_W 8
`define FIC_OFF_DATA_FIFO 8'h24
`define FIC_OFF_CAP 8'h30
`define FIC_OFF_XFIFO 8'h80
`define FIC_OFF_KIND 8'h04
`define FIC_BIT_RSV31 31
`define FIC_BIT_REV_HI 30
`define FIC_BIT_REV_LO 28
`define FIC_BIT_SIZE_HI 10
`define FIC_BIT_SIZE_LO 9
`define FIC_BIT_FIXED 8
`define FIC_BIT_CMDRDY 7
`define FIC_BIT_FALL 6
`define FIC_BIT_RISE 5
`define FIC_BIT_LOW 4
`define FIC_BIT_HIGH 3
`define FIC_BIT_OWNSW 2
`define FIC_BIT_STSOK 1
`define FIC_BIT_REPLY 0
`define FIC_KIND_FIFO_A 4'h0
`define FIC_KIND_FIFO_B 4'hf
`define FIC_REV_DEFAULT 3'h3
`define FIC_LEN_LEGACY 7'h04
`define FIC_LEN_8 7'h08
`define FIC_LEN_32 7'h20
`define FIC_LEN_64 7'h40
`endif

// ===== fic_fifo_model.sv
// fifo storage stand-in on the fifo port of fic_cap
// assumes read data is wanted in the cycle of the fifo_rd pulse
`timescale 1ns/1ps
`default_nettype none
module fic_fifo_model (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic fifo_rd,
   output logic [31:0] fifo_rdata
);
   logic [15:0] cnt;
   logic [15:0] cyc;
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         cnt <= 16'h0;
         cyc <= 16'h0;
      end
      else
      begin
         cyc <= cyc + 16'h1;
         if (fifo_rd)
            cnt <= cnt + 16'h1;
      end
   end
   // outside a read the bus wanders every cycle, so a stale sample never matches
   assign fifo_rdata = fifo_rd ? {16'hfeed, cnt} : {cyc, ~cyc};
endmodule : fic_fifo_model
`default_nettype wire

// ===== fic_pkg.sv
// types for the fifo interface capability block
// assumes fic_cfg.svh is on the include path
`include "fic_cfg.svh"
package fic_pkg;
   typedef enum logic [1:0] {FIC_SZ_LEGACY = 2'h0, FIC_SZ_8 = 2'h1, FIC_SZ_32 = 2'h2, FIC_SZ_64 = 2'h3} fic_size_e;
   typedef struct packed {
      logic rsv31;
      logic [2:0] port_revision;
      logic [16:0] rsv;
      fic_size_e max_xfer_size_cap;
      logic fixed_burst_flag;
      logic cmd_ready_irq_cap;
      logic fall_trigger_cap;
      logic rise_trigger_cap;
      logic low_trigger_cap;
      logic high_trigger_cap;
      logic owner_switch_irq_cap;
      logic status_good_irq_cap;
      logic reply_ready_irq_cap;
   } fic_cap_s;
   typedef struct packed {
      logic wr;
      logic rd;
      logic [`FIC_ADDR_W-1:0] addr;
      logic [6:0] len;
      logic [31:0] wdata;
   } fic_req_s;
endpackage : fic_pkg

// ===== tb_fic_cap.sv
// random bench for fic_cap: a 32-byte part and a legacy-only part side by side
// assumes fic_cfg.svh on the include path and fic_fifo_model beside it
`timescale 1ns/1ps
`default_nettype none
`include "fic_cfg.svh"
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin err_count++; $display("BAD %s exp %h got %h", n, e, s); end end
module tb_fic_cap;
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   fic_pkg::fic_req_s q = '0, p = '0, n;
   wire logic [31:0] rdata [2], fwd [2], frdat [2];
   wire logic [6:0] flen [2];
   wire logic abort [2], fwr [2], frd [2];
   logic [15:0] rcnt [2] = '{16'h0, 16'h0};
   logic [1:0] szs [2] = '{2'h2, 2'h0};
   logic [5:0] opts [2] = '{6'h36, 6'h00};
   logic [6:0] lens [8] = '{7'h0, 7'h4, 7'h5, 7'h8, 7'h9, 7'h20, 7'h21, 7'h40};
   int err_count = 0, cmp_count = 0, seed = 32'h3b1ac524, t;
   logic acc, fifo;
   always #2 mclk = ~mclk;
   for (genvar g = 0; g < 2; g++)
   begin : gen_part
      fic_cap #(.SIZE_CAP(g ? 2'h0 : 2'h2), .PORT_KIND(g ? 4'hf : 4'h0), .RSV31_VAL(g == 0),
         .FIXED_BURST(g == 0), .CMD_READY_CAP(g == 0), .RISE_CAP(g == 0), .HIGH_CAP(g == 0)) u_dut (
         .mclk(mclk), .sys_rst(sys_rst), .reg_addr(q.addr), .reg_wdata(q.wdata), .reg_wr(q.wr), .reg_rd(q.rd),
         .reg_len(q.len), .reg_rdata(rdata[g]), .bus_abort(abort[g]), .fifo_wr(fwr[g]), .fifo_rd(frd[g]),
         .fifo_wdata(fwd[g]), .fifo_len(flen[g]), .fifo_rdata(frdat[g]));
      fic_fifo_model u_fifo (.mclk(mclk), .sys_rst(sys_rst), .fifo_rd(frd[g]), .fifo_rdata(frdat[g]));
   end
   function automatic logic [31:0] exp_cap(input logic [1:0] sz, input logic [5:0] o);
      return {1'b0, `FIC_REV_DEFAULT, 17'h0, sz, o[5:2], 1'b1, o[1], 1'b1, o[0], 1'b1};
   endfunction : exp_cap
   function automatic logic ok(input logic [1:0] sz, input logic [7:0] a, input logic [6:0] l);
      logic [6:0] mx;
      mx = (sz == 2'h3) ? `FIC_LEN_64 : (sz == 2'h2) ? `FIC_LEN_32 : (sz == 2'h1) ? `FIC_LEN_8 : `FIC_LEN_LEGACY;
      return !(a == `FIC_OFF_XFIFO && sz == 2'h0) && (l <= `FIC_LEN_LEGACY || l <= mx);
   endfunction : ok
   task automatic check();
      for (int i = 0; i < 2; i++)
      begin
         fifo = (p.addr == `FIC_OFF_DATA_FIFO) || (p.addr == `FIC_OFF_XFIFO);
         acc = fifo && ok(szs[i], p.addr, p.len);
         `CHK("abort", (p.wr | p.rd) & fifo & ~acc, abort[i])
         `CHK("fifo_wr", p.wr & acc, fwr[i])
         `CHK("fifo_rd", p.rd & acc, frd[i])
         if (p.wr && acc)
            `CHK("fifo_len_data", {p.len, p.wdata}, {flen[i], fwd[i]})
         // bit 31 is free for the part to choose, so it is masked off
         if (p.rd && p.addr == `FIC_OFF_CAP)
            `CHK("cap", exp_cap(szs[i], opts[i]) & 32'h7fffffff, rdata[i] & 32'h7fffffff)
         else if (p.rd && acc)
            `CHK("fifo_rdata", {16'hfeed, rcnt[i]}, rdata[i])
         else if (!p.rd)
            `CHK("rdata_idle", 32'h0, rdata[i])
         if (p.rd && acc)
            rcnt[i]++;
      end
   endtask : check
   task automatic step(input fic_pkg::fic_req_s r);
      @(posedge mclk);
      q <= r;
      @(negedge mclk);
      check();
      p = r;
   endtask : step
   task automatic test_done();
      $display("compares %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : test_done
   initial
   begin
      repeat (2) @(posedge mclk);
      sys_rst <= 1'b0;
      // first sixteen hit the extended fifo at every corner length, back to back
      for (int k = 0; k < 400; k++)
      begin
         t = $random(seed);
         n.wr = (k < 16) ? (k < 8) : (t[0] & ~t[1]);
         n.rd = (k < 16) ? (k >= 8) : (t[1] & ~t[0]);
         n.addr = (k < 16 || t[3:2] == 2'h1) ? `FIC_OFF_XFIFO : t[3] ? `FIC_OFF_CAP : `FIC_OFF_DATA_FIFO;
         n.len = (k < 16) ? lens[k % 8] : t[4] ? lens[t[7:5]] : t[14:8];
         n.wdata = $random(seed);
         step(n);
      end
      step('0);
      step('0);
      test_done();
   end
   initial
   begin
      #100000;
      err_count++;
      test_done();
   end
endmodule : tb_fic_cap
`default_nettype wire
